// *** rtl/bst_pkg.sv ***
/*
  bst_pkg: constants and types for the boundary-scan test access port.
  Assumes it is compiled before every other file of the block.
*/
package bst_pkg;

  // instruction register
  localparam int unsigned INSTR_W = 3;
  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_SAMPLE = 3'h4;
  localparam logic [2:0] INSTR_IDCODE = 3'h6;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  // pattern loaded in capture-ir, low two bits fixed as 01
  localparam logic [2:0] INSTR_CAPTURE = 3'h1;

  // identification register layout
  localparam int unsigned ID_W = 32;
  localparam int unsigned ID_MARK_POS = 0;
  localparam int unsigned ID_PROD_LSB = 1;
  localparam int unsigned ID_PROD_W = 11;
  localparam int unsigned ID_PART_LSB = 12;
  localparam int unsigned ID_PART_W = 16;
  localparam int unsigned ID_REV_LSB = 28;
  localparam int unsigned ID_REV_W = 4;
  localparam logic ID_MARK = 1'h1;

  // pin scan chain
  localparam int unsigned CHAIN_LEN = 98;
  localparam int unsigned CHAIN_IN_BITS = 49;
  localparam int unsigned CHAIN_OUT_BITS = 49;

  // reset values
  localparam logic BYPASS_RST = 1'h0;
  localparam logic TDO_RST = 1'h0;

  typedef enum logic [15:0] {
    ST_TLR        = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } bst_state_type;

endpackage

// *** rtl/bst_scan_chain.sv ***
/*
  bst_scan_chain: the pin scan chain, a serial shift path with a latched
  parallel output that moves only on the falling test clock edge.
  Assumes its strobes come from the controller on the same test clock.
*/
`timescale 1ns/100ps
module bst_scan_chain
  import bst_pkg::*;
#(
  parameter int unsigned LEN = CHAIN_LEN
)
(
  input wire logic tck,
  input wire logic rst,
  input wire logic en,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic sin,
  input wire logic [LEN-1:0] cap_data,
  output logic sout,
  output logic [LEN-1:0] par_q
);

  logic [LEN-1:0] sr_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      sr_q <= '0;
    else if (en && capture)
      sr_q <= cap_data;
    else if (en && shift)
      sr_q <= {sin, sr_q[LEN-1:1]};
  end

  assign sout = sr_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // latched output keeps pins still while new data shifts through
  always_ff @(negedge tck or posedge rst)
  begin
    if (rst)
      par_q <= '0;
    else if (en && update)
      par_q <= sr_q;
  end

endmodule

// *** rtl/bst_tap.sv ***
/*
  bst_tap: boundary-scan test access port with controller, instruction,
  identification, pass and pin scan registers, plus the pin multiplexing.
  Assumes tck comes from the tester and is unrelated to mclk; tms and tdi
  change on falling tck; core_out is driven from mclk logic.
*/
`timescale 1ns/100ps
module bst_tap
  import bst_pkg::*;
#(
  parameter int unsigned NUM_IN = CHAIN_IN_BITS,
  parameter int unsigned NUM_OUT = CHAIN_OUT_BITS,
  // arbitrary identity values
  parameter logic [10:0] PRODUCER_ID = 11'h001,
  parameter logic [15:0] PART_ID = 16'h0001,
  parameter logic [3:0] REVISION_ID = 4'h0
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [NUM_IN-1:0] pin_in,
  output logic [NUM_OUT-1:0] pin_out,
  input wire logic [NUM_OUT-1:0] core_out,
  output logic [NUM_IN-1:0] core_in
);

  localparam int unsigned LEN = NUM_IN + NUM_OUT;
  localparam logic [ID_W-1:0] ID_VALUE = {REVISION_ID, PART_ID, PRODUCER_ID, ID_MARK};

  bst_state_type st_q;
  bst_state_type st_d;
  logic ce_s1_q;
  logic ce_s2_q;
  logic en;
  logic [INSTR_W-1:0] ir_sr_q;
  logic [INSTR_W-1:0] ir_q;
  logic [ID_W-1:0] id_sr_q;
  logic byp_q;
  logic tdo_q;
  logic tdo_oe_q;
  logic sel_chain;
  logic sel_id;
  logic sel_byp;
  logic extest_q;
  logic [LEN-1:0] pin_s1_q;
  logic [LEN-1:0] pin_s2_q;
  logic chain_so;
  logic [LEN-1:0] chain_par;
  logic ext_m1_q;
  logic ext_m2_q;
  logic [NUM_OUT-1:0] upd_m1_q;
  logic [NUM_OUT-1:0] upd_m2_q;
  logic [NUM_OUT-1:0] upd_m3_q;
  logic [NUM_IN-1:0] in_m1_q;
  logic [NUM_IN-1:0] in_m2_q;
  logic [NUM_OUT-1:0] pin_out_q;
  logic [NUM_IN-1:0] core_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock enable into the test clock domain; these flops are never frozen
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      ce_s1_q <= 1'h0;
      ce_s2_q <= 1'h0;
    end
    else
    begin
      ce_s1_q <= ce;
      ce_s2_q <= ce_s1_q;
    end
  end

  assign en = ce_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // controller
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_TLR: st_d = tms ? ST_TLR : ST_IDLE;
      ST_IDLE: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_d = tms ? ST_TLR : ST_CAPTURE_IR;
      ST_CAPTURE_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
      default: st_d = ST_TLR;
    endcase
  end

  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      st_q <= ST_TLR;
    else if (en)
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction register
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      ir_sr_q <= INSTR_CAPTURE;
    else if (en && st_q == ST_CAPTURE_IR)
      ir_sr_q <= INSTR_CAPTURE;
    else if (en && st_q == ST_SHIFT_IR)
      ir_sr_q <= {tdi, ir_sr_q[INSTR_W-1:1]};
  end

  // current instruction changes on falling tck so decode never glitches mid-shift
  always_ff @(negedge tck or posedge rst)
  begin
    if (rst)
      ir_q <= INSTR_IDCODE;
    else if (en && st_q == ST_TLR)
      ir_q <= INSTR_IDCODE;
    else if (en && st_q == ST_UPDATE_IR)
      ir_q <= ir_sr_q;
  end

  assign sel_chain = (ir_q == INSTR_EXTEST) || (ir_q == INSTR_SAMPLE);
  assign sel_id = (ir_q == INSTR_IDCODE);
  assign sel_byp = !sel_chain && !sel_id;

  ////////////////////////////////////////////////////////////////////////////
  // identification register
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      id_sr_q <= ID_VALUE;
    else if (en && sel_id && st_q == ST_CAPTURE_DR)
      id_sr_q <= ID_VALUE;
    else if (en && sel_id && st_q == ST_SHIFT_DR)
      id_sr_q <= {tdi, id_sr_q[ID_W-1:1]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // pass register
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      byp_q <= BYPASS_RST;
    else if (en && sel_byp && st_q == ST_CAPTURE_DR)
      byp_q <= BYPASS_RST;
    else if (en && sel_byp && st_q == ST_SHIFT_DR)
      byp_q <= tdi;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin levels into the test clock domain: inputs low, driven outputs high
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {pin_out_q, pin_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  bst_scan_chain #(
    .LEN(LEN)
  ) u_chain (
    .tck(tck),
    .rst(rst),
    .en(en),
    .capture(sel_chain && st_q == ST_CAPTURE_DR),
    .shift(sel_chain && st_q == ST_SHIFT_DR),
    .update(sel_chain && st_q == ST_UPDATE_DR),
    .sin(tdi),
    .cap_data(pin_s2_q),
    .sout(chain_so),
    .par_q(chain_par)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial output
  always_ff @(negedge tck or posedge rst)
  begin
    if (rst)
    begin
      tdo_q <= TDO_RST;
      tdo_oe_q <= 1'h0;
    end
    else if (en)
    begin
      tdo_oe_q <= (st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR);
      if (st_q == ST_SHIFT_IR)
        tdo_q <= ir_sr_q[0];
      else if (sel_chain)
        tdo_q <= chain_so;
      else if (sel_id)
        tdo_q <= id_sr_q[0];
      else
        tdo_q <= byp_q;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // pin drive mode, registered so the crossing sees a clean level
  always_ff @(posedge tck or posedge rst)
  begin
    if (rst)
      extest_q <= 1'h0;
    else if (en)
      extest_q <= (ir_q == INSTR_EXTEST);
  end

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: chain outputs only change in update-dr, so a three-flop
  // level crossing of the whole word, taken once two stages agree, settles within four mclk cycles
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_m1_q <= 1'h0;
      ext_m2_q <= 1'h0;
      upd_m1_q <= '0;
      upd_m2_q <= '0;
      upd_m3_q <= '0;
      in_m1_q <= '0;
      in_m2_q <= '0;
    end
    else if (ce)
    begin
      ext_m1_q <= extest_q;
      ext_m2_q <= ext_m1_q;
      upd_m1_q <= chain_par[LEN-1:NUM_IN];
      upd_m2_q <= upd_m1_q;
      upd_m3_q <= upd_m2_q;
      in_m1_q <= pin_in;
      in_m2_q <= in_m1_q;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_out_q <= '0;
      core_in_q <= '0;
    end
    else if (ce)
    begin
      // the word crosses with no handshake, so take it only once two samples agree
      if (!ext_m2_q)
        pin_out_q <= core_out;
      else if (upd_m2_q == upd_m3_q)
        pin_out_q <= upd_m3_q;
      core_in_q <= in_m2_q;
    end
  end

  assign pin_out = pin_out_q;
  assign core_in = core_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tlr_five;
    @(posedge tck) disable iff (rst)
    (en && tms) [*5] |=> (st_q == ST_TLR);
  endproperty
  a_tlr_five: assert property (p_tlr_five) else $error("tms high five edges missed reset");

  property p_tlr_idcode;
    @(posedge tck) disable iff (rst)
    en && (st_q == ST_TLR) |-> (ir_q == INSTR_IDCODE);
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("idcode not loaded in reset");

  property p_ir_shift;
    @(posedge tck) disable iff (rst)
    en && (st_q == ST_SHIFT_IR) |=> (ir_sr_q == {$past(tdi), $past(ir_sr_q[2:1])});
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("instruction shift order wrong");

  sequence s_id_capture;
    en && sel_id && (st_q == ST_CAPTURE_DR);
  endsequence

  property p_id_value;
    @(posedge tck) disable iff (rst)
    s_id_capture |=> (id_sr_q == ID_VALUE) && id_sr_q[ID_MARK_POS];
  endproperty
  a_id_value: assert property (p_id_value) else $error("identification value wrong");

  property p_id_shift;
    @(posedge tck) disable iff (rst)
    en && sel_id && (st_q == ST_SHIFT_DR) |=> (id_sr_q == {$past(tdi), $past(id_sr_q[31:1])});
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("identification shift order wrong");

  sequence s_byp_shift;
    en && sel_byp && (st_q == ST_SHIFT_DR);
  endsequence

  property p_byp_delay;
    @(posedge tck) disable iff (rst)
    s_byp_shift ##1 (st_q == ST_SHIFT_DR) |-> (byp_q == $past(tdi));
  endproperty
  a_byp_delay: assert property (p_byp_delay) else $error("pass register delay wrong");

  property p_tdo_oe;
    @(posedge tck) disable iff (rst)
    tdo_oe_q == ((st_q == ST_SHIFT_DR) || (st_q == ST_SHIFT_IR));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enable outside shift");

  property p_upd_only;
    @(posedge tck) disable iff (rst)
    $changed(chain_par) |-> (st_q == ST_UPDATE_DR) && sel_chain;
  endproperty
  a_upd_only: assert property (p_upd_only) else $error("chain output moved outside update");

  property p_pin_normal;
    @(posedge mclk) disable iff (rst)
    ce && !ext_m2_q |=> (pin_out_q == $past(core_out));
  endproperty
  a_pin_normal: assert property (p_pin_normal) else $error("normal pin path broken");

endmodule

// *** tb/bst_jtag_host.sv ***
/*
  bst_jtag_host: behavioural boundary-scan tester that drives the test port.
  Assumes the port under test samples on rising tck and drives tdo on falling tck.
*/
`timescale 1ns/100ps
module bst_jtag_host
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // tck stands low outside frames, as a real tester leaves it
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock: levels set while tck is low, tdo taken just before rising
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    tms = m;
    tdi = d;
    #80;
    // a released tdo reads as the inverse of its last level, so stray samples show
    o = tdo_oe ? tdo : ~tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask

  // outside shifts tdi toggles so a stale level is never mistaken for data
  task automatic tlr();
    logic o;
    logic oe;
    for (int i = 0; i < 5; i++)
      step(1'b1, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
  endtask

  // from idle: scan n bits, least significant first, back to idle
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output logic oe_all);
    logic o;
    logic oe;
    dout = '0;
    oe_all = 1'b1;
    step(1'b1, ~tdi, o, oe);
    if (ir)
      step(1'b1, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
    step(1'b0, ~tdi, o, oe);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all &= oe;
    end
    // enable must be gone once the controller has left the shift state
    step(1'b1, ~tdi, o, oe);
    oe_all &= ~oe;
    step(1'b0, ~tdi, o, oe);
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  tb_top: self-checking bench for the boundary-scan test access port.
  Assumes bst_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  import bst_pkg::*;
  localparam logic [31:0] ID_EXP = {4'h9, 16'h1c3e, 11'h2a5, 1'h1};
  localparam logic [48:0] C1 = 49'h1_5a5a_3c3c_0f0f;
  localparam logic [48:0] P1 = 49'h0_a5c3_96e1_7b2d;
  localparam logic [48:0] P2 = 49'h1_0f1e_2d3c_4b5a;
  localparam logic [97:0] S = 98'h2_1b2c_3d4e_5f60_7182_93a4_b5c6;
  localparam logic [97:0] X = 98'h1_e3f5_0a1b_2c3d_4e5f_6071_8293;
  localparam logic [97:0] Y = 98'h3_579b_df02_468a_ce15_a5ac_3c3e;
  logic mclk = 1'b0;
  logic rst;
  logic ce;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic [48:0] pin_in;
  logic [48:0] pin_out;
  logic [48:0] core_out;
  logic [48:0] core_in;
  logic [127:0] dout;
  logic oe;
  int error_cnt = 0;
  int n_tests = 0;

  always #10 mclk = ~mclk;

  bst_tap #(.PRODUCER_ID(11'h2a5), .PART_ID(16'h1c3e), .REVISION_ID(4'h9)) bst_tap_i
  (
    .mclk(mclk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
    .core_out(core_out), .core_in(core_in)
  );

  bst_jtag_host bst_jtag_host_i
  (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // pins settle a few mclk after the falling tck edge; bounded wait
  task automatic wait_pins(input string name, input logic [48:0] exp);
    for (int k = 0; k < 20 && pin_out !== exp; k++)
      @(posedge mclk);
    check(name, pin_out, exp);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idcode();
    bst_jtag_host_i.tlr();
    bst_jtag_host_i.scan(1'b0, 32, 128'h0, dout, oe);
    check("idcode", dout, ID_EXP);
    check("tdo_enable", oe, 1'b1);
  endtask

  task automatic t_bypass();
    logic [2:0] codes [5] = '{3'h7, 3'h3, 3'h1, 3'h2, 3'h5};
    foreach (codes[i])
    begin
      bst_jtag_host_i.scan(1'b1, 3, {125'h0, codes[i]}, dout, oe);
      check("ir_capture", dout, 128'h1);
      bst_jtag_host_i.scan(1'b0, 16, 128'hb4e1, dout, oe);
      check("pass_path", dout, {112'h0, 16'hb4e1 << 1});
    end
  endtask

  task automatic t_sample();
    bst_jtag_host_i.scan(1'b1, 3, 128'h4, dout, oe);
    bst_jtag_host_i.scan(1'b0, 98, {30'h0, S}, dout, oe);
    check("sample_capture", dout, {30'h0, C1, P1});
    repeat (10) @(posedge mclk);
    #3;
    check("sample_pins", pin_out, C1);
    check("sample_core_in", core_in, P1);
  endtask

  task automatic t_extest();
    bst_jtag_host_i.scan(1'b1, 3, 128'h0, dout, oe);
    wait_pins("preload_pins", S[97:49]);
    #3;
    bst_jtag_host_i.scan(1'b0, 98, {30'h0, X}, dout, oe);
    check("extest_capture1", dout, {30'h0, S[97:49], P1});
    wait_pins("extest_pins1", X[97:49]);
    pin_in <= P2;
    repeat (10) @(posedge mclk);
    #3;
    bst_jtag_host_i.scan(1'b0, 98, {30'h0, Y}, dout, oe);
    check("extest_capture2", dout, {30'h0, X[97:49], P2});
    wait_pins("extest_pins2", Y[97:49]);
  endtask

  // abandon a data scan in mid-shift with five high tms levels
  task automatic t_tms_reset();
    logic o;
    #3;
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b1, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.tlr();
    wait_pins("normal_pins", C1);
    #3;
    bst_jtag_host_i.scan(1'b0, 32, 128'h0, dout, oe);
    check("idcode_again", dout, ID_EXP);
  endtask

  // both pause loops: code 111 through pause-ir, then a pass scan through pause-dr
  task automatic t_pause();
    logic o;
    logic [3:0] v;
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b1, v[0], oe);
    bst_jtag_host_i.step(1'b1, 1'b1, v[1], oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    check("pause_ir_tdo_enable", oe, 1'b0);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b1, 1'b1, v[2], oe);
    check("pause_ir_capture", v[2:0], 3'h1);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b1, v[0], oe);
    bst_jtag_host_i.step(1'b1, 1'b0, v[1], oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    check("pause_dr_tdo_enable", oe, 1'b0);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b1, v[2], oe);
    bst_jtag_host_i.step(1'b1, 1'b1, v[3], oe);
    bst_jtag_host_i.step(1'b1, 1'b0, o, oe);
    bst_jtag_host_i.step(1'b0, 1'b0, o, oe);
    check("pause_dr_pass", v, 4'ha);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    pin_in = P1;
    core_out = C1;
    repeat (10) @(posedge mclk);
    check("rst_tdo_oe", tdo_oe, 1'b0);
    check("rst_pins", pin_out, 49'h0);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    // keep tck edges off the mclk edges
    #3;
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_tms_reset();
    t_pause();
    tally_and_finish();
  end
endmodule
